//--- rtl/lut_pkg.sv
// Shared constants and types for the piecewise lookup table
`default_nettype none

package lut_pkg;

  // ------------------------------------------------------------
  // Table geometry
  // ------------------------------------------------------------
  localparam int NPTS = 11;
  localparam logic [3:0] IDX_FIRST = 4'h0;
  localparam logic [3:0] IDX_LAST = 4'hA;
  localparam int XW = 16;
  localparam int YW = 16;
  localparam int DYW = YW + 1;
  localparam int PW = DYW + XW;
  localparam int KINDW = 2;
  localparam int NUMW = 2;
  localparam int NSRC = 16;

  // ------------------------------------------------------------
  // Segment shapes and axis modes
  // ------------------------------------------------------------
  localparam logic [1:0] SHAPE_IGNORE = 2'h0;
  localparam logic [1:0] SHAPE_LINEAR = 2'h1;
  localparam logic [1:0] SHAPE_STEP = 2'h2;
  localparam logic [1:0] SHAPE_BAD = 2'h3;
  localparam logic AXIS_DATA = 1'h0;
  localparam logic AXIS_TIME = 1'h1;

  // ------------------------------------------------------------
  // Timing: 1 ms time base from the 100 ns clock
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_TICK_NS = 1_000_000;
  localparam int MS_CYCLES = MS_TICK_NS / CLK_PERIOD_NS;
  localparam logic [XW-1:0] X_RST = 16'h0000;
  localparam logic [YW-1:0] Y_RST = 16'h0000;
  localparam logic [XW-1:0] X_FULL = 16'hFFFF;

  typedef struct packed {
    logic [XW-1:0] x;
    logic signed [YW-1:0] y;
    logic [1:0] shape;
  } point_t;

endpackage

`default_nettype wire

//--- rtl/lut_divider.sv
// Serial restoring divider used for linear segment interpolation
`default_nettype none

module lut_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Request
  input wire logic start,
  input wire logic [lut_pkg::PW-1:0] dividend,
  input wire logic [lut_pkg::XW-1:0] divisor,
  // Result
  output logic busy,
  output logic done,
  output logic [lut_pkg::PW-1:0] quotient
);

  logic [lut_pkg::XW:0] rem_q;
  logic [lut_pkg::XW:0] rem_sh;
  logic [lut_pkg::XW-1:0] div_q;
  logic [5:0] cnt_q;

  assign rem_sh = {rem_q[lut_pkg::XW-1:0], quotient[lut_pkg::PW-1]};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt_q <= 6'h00;
      rem_q <= '0;
      div_q <= '0;
      quotient <= '0;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt_q <= 6'(lut_pkg::PW);
        rem_q <= '0;
        div_q <= divisor;
        quotient <= dividend;
      end else if (busy) begin
        if (rem_sh >= {1'b0, div_q}) begin
          rem_q <= rem_sh - {1'b0, div_q};
          quotient <= {quotient[lut_pkg::PW-2:0], 1'b1};
        end else begin
          rem_q <= rem_sh;
          quotient <= {quotient[lut_pkg::PW-2:0], 1'b0};
        end
        cnt_q <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  div_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    (start && !busy) |-> ##34 done) else $error("divider result late or early"); // [R07]

endmodule

`default_nettype wire

//--- rtl/piecewise_lookup_table.sv
// Piecewise lookup table: eleven points, step or linear segments, data or time axis
`default_nettype none

// Functional notes
// [R01] Eleven points, index zero to ten
// [R02] Axis mode: 0 data input, 1 time
// [R03] Data mode compares points to selected source
// [R04] Time mode: X in ms, source enables
// [R05] Loop restarts time base; none in data
// [R06] Shape codes: 0 ignore, 1 linear, 2 step
// [R07] Linear segment interpolates between neighbouring points
// [R08] Step segment outputs this point's Y
// [R09] Point zero shape always step, unwritable
// [R10] Ignore drops this and higher points
// [R11] X points non-decreasing, within input limits
// [R12] Software rewrites X from highest index down
// [R13] Report smallest and largest active Y
// [R14] Ignored points excluded from min, max
// [R15] Clamp below first, hold after last
// [R16] Time counter clears when enable low
module piecewise_lookup_table #(
  parameter int MS_CYCLES = lut_pkg::MS_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Mode and input selection
  input wire logic axis_mode,
  input wire logic loop_en,
  input wire logic [lut_pkg::KINDW-1:0] src_kind,
  input wire logic [lut_pkg::NUMW-1:0] src_num,
  input wire logic [lut_pkg::NSRC-1:0][lut_pkg::XW-1:0] src_data,
  input wire logic [lut_pkg::XW-1:0] x_lo,
  input wire logic [lut_pkg::XW-1:0] x_hi,
  // Point write port
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_idx,
  input wire lut_pkg::point_t cfg_pt,
  output logic cfg_err,
  // Results
  output logic signed [lut_pkg::YW-1:0] y_out,
  output logic out_valid,
  output logic signed [lut_pkg::YW-1:0] out_min,
  output logic signed [lut_pkg::YW-1:0] out_max,
  output logic [lut_pkg::XW-1:0] elapsed_ms
);

  typedef enum logic {ST_IDLE, ST_DIV} state_t;

  lut_pkg::point_t [lut_pkg::NPTS-1:0] pts_q;
  state_t state_q;
  logic [31:0] ms_cnt_q;
  logic [3:0] last, seg, prev;
  logic [lut_pkg::XW-1:0] sel_val, xin, span, dx, x_last;
  logic signed [lut_pkg::DYW-1:0] dy;
  logic [lut_pkg::DYW-1:0] dy_mag;
  logic [lut_pkg::PW-1:0] prod, quo;
  logic signed [lut_pkg::YW-1:0] direct_y, base_q, mn, mx;
  logic time_mode, time_en, tick, below, beyond, need_div, wr_ok, x_sorted;
  logic neg_q, div_busy, div_done;

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] last_active(input lut_pkg::point_t [lut_pkg::NPTS-1:0] p);
    logic [3:0] r;
    logic stop;
    r = lut_pkg::IDX_LAST;
    stop = 1'b0;
    for (int i = 1; i < lut_pkg::NPTS; i++) begin
      if (!stop && p[i].shape == lut_pkg::SHAPE_IGNORE) begin
        r = 4'(i - 1);
        stop = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic is_step(input logic [1:0] s);
    return s == lut_pkg::SHAPE_STEP;
  endfunction

  assign last = last_active(pts_q); // [R10]
  assign x_last = pts_q[last].x;
  assign sel_val = src_data[{src_kind, src_num}]; // [R03]
  assign time_mode = (axis_mode == lut_pkg::AXIS_TIME); // [R02]
  assign time_en = time_mode && (sel_val != lut_pkg::X_RST); // [R04]
  assign xin = time_mode ? elapsed_ms : sel_val; // [R02] [R04]

  // ------------------------------------------------------------
  // Point storage and ordered writes
  // ------------------------------------------------------------
  always_comb begin
    wr_ok = cfg_wr && (cfg_idx <= lut_pkg::IDX_LAST) && (cfg_pt.x >= x_lo) &&
            (cfg_pt.x <= x_hi) && (cfg_pt.shape != lut_pkg::SHAPE_BAD); // [R11]
    if (cfg_idx != lut_pkg::IDX_FIRST && cfg_idx <= lut_pkg::IDX_LAST &&
        cfg_pt.x < pts_q[cfg_idx - 4'h1].x) begin
      wr_ok = 1'b0; // [R11]
    end
    if (cfg_idx < lut_pkg::IDX_LAST && cfg_pt.x > pts_q[cfg_idx + 4'h1].x) begin
      wr_ok = 1'b0; // [R11]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < lut_pkg::NPTS; i++) begin
        pts_q[i].x <= lut_pkg::X_RST;
        pts_q[i].y <= lut_pkg::Y_RST;
        pts_q[i].shape <= (i == 0) ? lut_pkg::SHAPE_STEP : lut_pkg::SHAPE_IGNORE;
      end
    end else if (wr_ok) begin
      pts_q[cfg_idx] <= cfg_pt; // [R01]
      if (cfg_idx == lut_pkg::IDX_FIRST) begin
        pts_q[lut_pkg::IDX_FIRST].shape <= lut_pkg::SHAPE_STEP; // [R09]
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg_err <= 1'b0;
    end else begin
      cfg_err <= cfg_wr && !wr_ok; // [R11]
    end
  end

  // ------------------------------------------------------------
  // Millisecond time base
  // ------------------------------------------------------------
  assign tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!reset_n || !time_en || tick) begin
      ms_cnt_q <= 32'h0000_0000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !time_en) begin
      elapsed_ms <= lut_pkg::X_RST; // [R16]
    end else if (tick) begin
      if (loop_en && elapsed_ms >= x_last) begin
        elapsed_ms <= lut_pkg::X_RST; // [R05]
      end else if (elapsed_ms != lut_pkg::X_FULL) begin
        elapsed_ms <= elapsed_ms + 16'h0001; // [R16]
      end
    end
  end

  // ------------------------------------------------------------
  // Segment search
  // ------------------------------------------------------------
  always_comb begin
    seg = last;
    for (int i = lut_pkg::NPTS - 1; i >= 1; i--) begin
      if (4'(i) <= last && xin <= pts_q[i].x) begin
        seg = 4'(i);
      end
    end
    prev = (seg == lut_pkg::IDX_FIRST) ? lut_pkg::IDX_FIRST : seg - 4'h1;
    below = xin < pts_q[lut_pkg::IDX_FIRST].x; // [R15]
    beyond = xin > x_last; // [R15]
    span = pts_q[seg].x - pts_q[prev].x;
    dx = xin - pts_q[prev].x;
    dy = lut_pkg::DYW'(pts_q[seg].y) - lut_pkg::DYW'(pts_q[prev].y);
    dy_mag = dy[lut_pkg::DYW-1] ? lut_pkg::DYW'(-dy) : lut_pkg::DYW'(dy);
    prod = lut_pkg::PW'(dy_mag) * lut_pkg::PW'(dx);
    if (below) begin
      direct_y = pts_q[lut_pkg::IDX_FIRST].y; // [R15]
    end else if (beyond) begin
      direct_y = pts_q[last].y; // [R15]
    end else begin
      direct_y = pts_q[seg].y; // [R08]
    end
    need_div = !below && !beyond && (pts_q[seg].shape == lut_pkg::SHAPE_LINEAR) &&
               (span != lut_pkg::X_RST); // [R06] [R07]
  end

  lut_divider i_lut_divider (
    .clk(clk),
    .reset_n(reset_n),
    .start(state_q == ST_IDLE && need_div),
    .dividend(prod),
    .divisor(span),
    .busy(div_busy),
    .done(div_done),
    .quotient(quo)
  );

  // ------------------------------------------------------------
  // Output sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      base_q <= lut_pkg::Y_RST;
      neg_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (need_div) begin
            state_q <= ST_DIV;
            base_q <= pts_q[prev].y;
            neg_q <= dy[lut_pkg::DYW-1];
          end
        end
        ST_DIV: begin
          if (div_done) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      y_out <= lut_pkg::Y_RST;
      out_valid <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      if (state_q == ST_IDLE && !need_div) begin
        y_out <= direct_y; // [R08] [R15]
        out_valid <= 1'b1;
      end else if (state_q == ST_DIV && div_done) begin
        y_out <= neg_q ? base_q - lut_pkg::YW'(quo) : base_q + lut_pkg::YW'(quo); // [R07]
        out_valid <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Output range from active points
  // ------------------------------------------------------------
  always_comb begin
    mn = pts_q[lut_pkg::IDX_FIRST].y;
    mx = pts_q[lut_pkg::IDX_FIRST].y;
    x_sorted = 1'b1;
    for (int i = 1; i < lut_pkg::NPTS; i++) begin
      if (4'(i) <= last) begin
        if (pts_q[i].y < mn) mn = pts_q[i].y; // [R13] [R14]
        if (pts_q[i].y > mx) mx = pts_q[i].y; // [R13] [R14]
      end
      if (pts_q[i].x < pts_q[i-1].x) x_sorted = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      out_min <= lut_pkg::Y_RST;
      out_max <= lut_pkg::Y_RST;
    end else begin
      out_min <= mn; // [R13]
      out_max <= mx; // [R13]
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  shape_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    is_step(pts_q[lut_pkg::IDX_FIRST].shape)) else $error("point zero not step"); // [R09]
  x_order_a: assert property (@(posedge clk) disable iff (!reset_n)
    x_sorted) else $error("x points out of order"); // [R11]
  bad_write_a: assert property (@(posedge clk) disable iff (!reset_n)
    (cfg_wr && cfg_idx > lut_pkg::IDX_LAST) |=> cfg_err) else $error("bad index taken"); // [R11]
  time_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    !time_en |=> elapsed_ms == lut_pkg::X_RST) else $error("time not cleared"); // [R16]
  loop_wrap_a: assert property (@(posedge clk) disable iff (!reset_n)
    (time_en && tick && loop_en && elapsed_ms >= x_last) |=> elapsed_ms == lut_pkg::X_RST)
    else $error("time base did not wrap"); // [R05]
  time_step_a: assert property (@(posedge clk) disable iff (!reset_n)
    (time_en && tick && !loop_en && elapsed_ms != lut_pkg::X_FULL) |=>
    elapsed_ms == $past(elapsed_ms) + 16'h0001) else $error("time base stalled"); // [R16]
  step_seg_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_IDLE && !below && !beyond && is_step(pts_q[seg].shape)) |=>
    (out_valid && y_out == $past(direct_y))) else $error("step output wrong"); // [R08]
  range_order_a: assert property (@(posedge clk) disable iff (!reset_n)
    out_min <= out_max) else $error("output range inverted"); // [R13]
  linear_done_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q == ST_IDLE && need_div) |=> !out_valid ##34 out_valid)
    else $error("linear result timing"); // [R07]

endmodule

`default_nettype wire

//--- tb/tb_piecewise_lookup_table.sv
// Self-checking testbench for the piecewise lookup table
`default_nettype none

module tb_piecewise_lookup_table;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------
  // Signals
  // ----------------------------------------------------------
  localparam int MSC = 10;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic axis_mode = lut_pkg::AXIS_DATA;
  logic loop_en = 1'b0;
  logic [lut_pkg::KINDW-1:0] src_kind = 2'h2;
  logic [lut_pkg::NUMW-1:0] src_num = 2'h1;
  logic [lut_pkg::NSRC-1:0][lut_pkg::XW-1:0] src_data = '0;
  logic [lut_pkg::XW-1:0] x_lo = 16'h0000;
  logic [lut_pkg::XW-1:0] x_hi = 16'hFFFF;
  logic cfg_wr = 1'b0;
  logic [3:0] cfg_idx = 4'h0;
  lut_pkg::point_t cfg_pt = '0;
  logic cfg_err, out_valid;
  logic signed [lut_pkg::YW-1:0] y_out, out_min, out_max;
  logic [lut_pkg::XW-1:0] elapsed_ms, e1;
  int error_cnt = 0;
  int checks = 0;
  int cyc = 0;

  always #50 clk = ~clk;

  piecewise_lookup_table #(.MS_CYCLES(MSC)) i_piecewise_lookup_table (
    .clk(clk), .reset_n(reset_n), .axis_mode(axis_mode), .loop_en(loop_en),
    .src_kind(src_kind), .src_num(src_num), .src_data(src_data), .x_lo(x_lo),
    .x_hi(x_hi), .cfg_wr(cfg_wr), .cfg_idx(cfg_idx), .cfg_pt(cfg_pt), .cfg_err(cfg_err),
    .y_out(y_out), .out_valid(out_valid), .out_min(out_min), .out_max(out_max),
    .elapsed_ms(elapsed_ms)
  );

  // ----------------------------------------------------------
  // Compare, access and closing tasks
  // ----------------------------------------------------------
  task automatic chk16(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk1(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One point write; a refusal shows as a one-cycle pulse in the next cycle
  task automatic wr(input logic [3:0] idx, input logic [15:0] x, input logic [15:0] y,
                    input logic [1:0] sh, input logic exp_err);
    logic e;
    cfg_wr = 1'b1;
    cfg_idx = idx;
    cfg_pt.x = x;
    cfg_pt.y = y;
    cfg_pt.shape = sh;
    @(negedge clk);
    cfg_wr = 1'b0;
    e = cfg_err;
    @(negedge clk);
    chk1("cfg_err", exp_err, e);
    chk1("cfg_err_end", 1'b0, cfg_err);
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    while (out_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk1("out_valid", 1'b1, out_valid);
  endtask

  // Drive one source and wait past a full division before checking
  task automatic ev(input int idx, input logic [15:0] x, input logic [15:0] y);
    src_data[idx] = x;
    repeat (75) @(negedge clk);
    wait_valid();
    chk16("y_out", y, y_out);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    chk16("y_out_rst", 16'h0000, y_out);
    chk16("max_rst", 16'h0000, out_max);
    chk16("elapsed_rst", 16'h0000, elapsed_ms);
    for (int i = 10; i >= 3; i--) begin
      wr(4'(i), 16'h03E8, 16'h01F4, lut_pkg::SHAPE_IGNORE, 1'b0);
    end
    wr(4'h2, 16'h00C8, 16'hFFCE, lut_pkg::SHAPE_STEP, 1'b0);
    wr(4'h1, 16'h0064, 16'h0064, lut_pkg::SHAPE_LINEAR, 1'b0);
    wr(4'h0, 16'h000A, 16'h0014, lut_pkg::SHAPE_IGNORE, 1'b0);
    wr(4'h1, 16'h012C, 16'h0000, lut_pkg::SHAPE_LINEAR, 1'b1);
    wr(4'h2, 16'h0032, 16'h0000, lut_pkg::SHAPE_STEP, 1'b1);
    wr(4'h2, 16'h00C8, 16'h0000, lut_pkg::SHAPE_BAD, 1'b1);
    wr(4'hB, 16'h03E8, 16'h0000, lut_pkg::SHAPE_STEP, 1'b1);
    x_hi = 16'h07D0;
    wr(4'hA, 16'h0BB8, 16'h0000, lut_pkg::SHAPE_IGNORE, 1'b1);
    x_hi = 16'hFFFF;
    x_lo = 16'h0005;
    wr(4'h0, 16'h0002, 16'h0000, lut_pkg::SHAPE_STEP, 1'b1);
    x_lo = 16'h0000;
    // Data axis
    ev(9, 16'h0005, 16'h0014);
    ev(9, 16'h0037, 16'h003C);
    ev(9, 16'h0064, 16'h0064);
    ev(9, 16'h0096, 16'hFFCE);
    ev(9, 16'h00FA, 16'hFFCE);
    chk16("out_min", 16'hFFCE, out_min);
    chk16("out_max", 16'h0064, out_max);
    src_kind = 2'h0;
    src_num = 2'h3;
    ev(3, 16'h0037, 16'h003C);
    src_kind = 2'h2;
    src_num = 2'h1;
    wr(4'h3, 16'h03E8, 16'h01F4, lut_pkg::SHAPE_STEP, 1'b0);
    ev(9, 16'h00FA, 16'h01F4);
    chk16("out_max_p3", 16'h01F4, out_max);
    wr(4'h3, 16'h03E8, 16'h01F4, lut_pkg::SHAPE_IGNORE, 1'b0);
    ev(9, 16'h00FA, 16'hFFCE);
    chk16("out_max_drop", 16'h0064, out_max);
    // Falling linear segment, exact and truncated towards the lower point's Y
    wr(4'h2, 16'h00C8, 16'hFFCE, lut_pkg::SHAPE_LINEAR, 1'b0);
    ev(9, 16'h0096, 16'h0019);
    ev(9, 16'h00A1, 16'h0009);
    // Time axis
    src_data[9] = 16'h0000;
    axis_mode = lut_pkg::AXIS_TIME;
    repeat (30) @(negedge clk);
    chk16("elapsed_off", 16'h0000, elapsed_ms);
    src_data[9] = 16'h0001;
    repeat (2) @(negedge clk);
    e1 = elapsed_ms;
    repeat (10 * MSC) @(negedge clk);
    chk16("elapsed_step", 16'h000A, elapsed_ms - e1);
    src_data[9] = 16'h0000;
    repeat (3) @(negedge clk);
    chk16("elapsed_clr", 16'h0000, elapsed_ms);
    src_data[9] = 16'h0001;
    repeat (260 * MSC) @(negedge clk);
    chk1("elapsed_hold", 1'b1, elapsed_ms > 16'h00C8);
    wait_valid();
    chk16("y_time_end", 16'hFFCE, y_out);
    loop_en = 1'b1;
    repeat (3 * MSC) @(negedge clk);
    chk1("elapsed_wrap", 1'b1, elapsed_ms < 16'h000A);
    repeat (210 * MSC) @(negedge clk);
    chk1("elapsed_rewrap", 1'b1, elapsed_ms <= 16'h00C8);
    axis_mode = lut_pkg::AXIS_DATA;
    repeat (3) @(negedge clk);
    chk16("elapsed_data", 16'h0000, elapsed_ms);
    ev(9, 16'h0037, 16'h003C);
    give_verdict();
  end
endmodule

`default_nettype wire
